// ---- alarm_ref_pkg.sv ----
// package: constants and types for the alarm tone and reference clock block
package alarm_ref_pkg;

  // ==========================================================
  // clock and output frequencies
  localparam longint CLK_HZ       = 100_000_000;
  localparam longint F_2K_HZ      = 2000;
  localparam longint F_4K_HZ      = 4000;
  localparam longint F_3K2_DHZ    = 32000;  // tenths of Hz
  localparam longint F_2K7_DHZ    = 27000;  // tenths of Hz
  localparam longint F_RTC_HZ     = 32768;
  localparam longint F_16K_HZ     = 16000;
  localparam longint F_19K_HZ     = 19000;
  localparam longint F_64_HZ      = 64;
  localparam longint F_16_HZ      = 16;
  localparam longint T_SLOW_S     = 60;     // period of the 1/60 Hz output

  // ==========================================================
  // half-period counts in clk_sys cycles
  localparam int unsigned HALF_2K   = int'(CLK_HZ / (2 * F_2K_HZ));
  localparam int unsigned HALF_4K   = int'(CLK_HZ / (2 * F_4K_HZ));
  localparam int unsigned HALF_3K2  = int'(CLK_HZ * 10 / (2 * F_3K2_DHZ));
  localparam int unsigned HALF_2K7  = int'(CLK_HZ * 10 / (2 * F_2K7_DHZ));
  localparam int unsigned HALF_RTC  = int'(CLK_HZ / (2 * F_RTC_HZ));
  localparam int unsigned HALF_16K  = int'(CLK_HZ / (2 * F_16K_HZ));
  localparam int unsigned HALF_19K  = int'(CLK_HZ / (2 * F_19K_HZ));
  localparam int unsigned HALF_64   = int'(CLK_HZ / (2 * F_64_HZ));
  localparam int unsigned HALF_16   = int'(CLK_HZ / (2 * F_16_HZ));
  localparam int unsigned HALF_SLOW = int'(CLK_HZ * T_SLOW_S / 2);

  // ==========================================================
  // register map
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  localparam int CTRL_W   = 7;
  localparam int IRQ_W    = 3;
  localparam int STATUS_W = 3;

  // event bit positions
  localparam int EV_LOW_SET = 0;
  localparam int EV_LOW_CLR = 1;
  localparam int EV_SAMPLE  = 2;

  // last run count of the battery sense filter; four equal samples change the flag
  localparam logic [1:0] BAT_RUN_LAST = 2'h3;

  // ==========================================================
  // option word held in the control register
  typedef struct packed {
    logic       vendor_algo_opt;
    logic       ref_b_freq_sel_hi;
    logic       ref_b_freq_sel_lo;
    logic [1:0] ref_a_freq_sel;
    logic       ref_a_disable_opt;
    logic       battery_detect_src_sel;
  } opt_t;

  localparam opt_t CTRL_RST = opt_t'(7'h03);
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } reg_req_t;

endpackage : alarm_ref_pkg

// ---- alarm_ref_clock.sv ----
// alarm tone, reference clock outputs and battery-low detector
`timescale 1ns/1ps
`default_nettype none

module alarm_ref_clock #(
  parameter bit          XTAL_76K  = 1'b0,
  parameter int unsigned P_2K      = alarm_ref_pkg::HALF_2K,
  parameter int unsigned P_4K      = alarm_ref_pkg::HALF_4K,
  parameter int unsigned P_3K2     = alarm_ref_pkg::HALF_3K2,
  parameter int unsigned P_2K7     = alarm_ref_pkg::HALF_2K7,
  parameter int unsigned P_RTC     = alarm_ref_pkg::HALF_RTC,
  parameter int unsigned P_16K     = alarm_ref_pkg::HALF_16K,
  parameter int unsigned P_19K     = alarm_ref_pkg::HALF_19K,
  parameter int unsigned P_64      = alarm_ref_pkg::HALF_64,
  parameter int unsigned P_16      = alarm_ref_pkg::HALF_16,
  parameter int unsigned P_SLOW    = alarm_ref_pkg::HALF_SLOW
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire alarm_ref_pkg::reg_req_t reg_req,
  output var  logic [31:0]           reg_rdata,
  input  wire logic                  alarm_freq_sel0,
  input  wire logic                  alarm_freq_sel1,
  input  wire logic                  alarm_enable_in,
  input  wire logic                  ref_b_enable_in,
  input  wire logic                  rf_power_ctrl,
  input  wire logic                  opt_wait_done,
  output var  logic                  alarm_tone_out,
  output var  logic                  alarm_tone_oe,
  output var  logic                  ref_clock_out_a,
  output var  logic                  ref_clock_out_b,
  output var  logic                  battery_low_flag_out,
  output var  logic                  irq
);
  import alarm_ref_pkg::*;

  localparam int NCH = 3;  // 0 alarm, 1 ref A, 2 ref B

  // ==========================================================
  // parameter checks
  if (P_2K < 2 || P_4K < 2 || P_3K2 < 2 || P_2K7 < 2 || P_RTC < 2 ||
      P_16K < 2 || P_19K < 2 || P_64 < 2 || P_16 < 2 || P_SLOW < 2) begin : g_chk
    $error("half-period counts must be at least two cycles");
  end

  // ==========================================================
  // registers
  opt_t             ctrl_q,     ctrl_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [31:0]      rdata_q,    rdata_d;
  logic             irq_q,      irq_d;
  logic [IRQ_W-1:0] ev;
  logic [STATUS_W-1:0] status;

  always_comb begin
    ctrl_d     = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    rdata_d    = 32'h0;
    if (reg_req.we) begin
      unique case (reg_req.addr)
        OFS_CTRL:     ctrl_d     = opt_t'(reg_req.wdata[CTRL_W-1:0]);
        OFS_IRQ_STAT: irq_stat_d = irq_stat_q & ~reg_req.wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: irq_mask_d = reg_req.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    irq_stat_d = irq_stat_d | ev;
    if (reg_req.re) begin
      unique case (reg_req.addr)
        OFS_CTRL:     rdata_d = {25'h0, ctrl_q};
        OFS_STATUS:   rdata_d = {29'h0, status};
        OFS_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
        OFS_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
        default:      rdata_d = 32'h0;
      endcase
    end
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= CTRL_RST;
      irq_stat_q <= 3'h0;
      irq_mask_q <= IRQ_MASK_RST;
      rdata_q    <= 32'h0;
      irq_q      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      rdata_q    <= rdata_d;
      irq_q      <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

  // ==========================================================
  // battery-low detector
  logic       rf_prev_q, rf_prev_d;
  logic [1:0] hi_cnt_q,  hi_cnt_d;
  logic [1:0] lo_cnt_q,  lo_cnt_d;
  logic       bat_low_q, bat_low_d;
  logic       smp;
  logic       sense;

  assign sense = alarm_freq_sel1;  // shared pin when source option is zero
  assign smp = rf_power_ctrl & ~rf_prev_q & ~ctrl_q.battery_detect_src_sel;

  always_comb begin
    rf_prev_d = rf_power_ctrl;
    hi_cnt_d  = hi_cnt_q;
    lo_cnt_d  = lo_cnt_q;
    bat_low_d = bat_low_q;
    if (smp) begin
      if (sense) begin
        lo_cnt_d = 2'h0;
        if (hi_cnt_q == BAT_RUN_LAST) bat_low_d = 1'b1;
        else hi_cnt_d = hi_cnt_q + 2'h1;
      end else begin
        hi_cnt_d = 2'h0;
        if (lo_cnt_q == BAT_RUN_LAST) bat_low_d = 1'b0;
        else lo_cnt_d = lo_cnt_q + 2'h1;
      end
    end
    ev = 3'h0;
    ev[EV_LOW_SET] = bat_low_d & ~bat_low_q;
    ev[EV_LOW_CLR] = ~bat_low_d & bat_low_q;
    ev[EV_SAMPLE]  = smp;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rf_prev_q <= 1'b0;
      hi_cnt_q  <= 2'h0;
      lo_cnt_q  <= 2'h0;
      bat_low_q <= 1'b0;
    end else begin
      rf_prev_q <= rf_prev_d;
      hi_cnt_q  <= hi_cnt_d;
      lo_cnt_q  <= lo_cnt_d;
      bat_low_q <= bat_low_d;
    end
  end

  assign battery_low_flag_out = bat_low_q;

  // ==========================================================
  // frequency selection
  logic       sel1_eff;
  logic [31:0] half_sel [NCH];

  assign sel1_eff = ctrl_q.battery_detect_src_sel ? alarm_freq_sel1 : 1'b1;
  assign status   = {opt_wait_done, sel1_eff, bat_low_q};

  always_comb begin
    unique case ({sel1_eff, alarm_freq_sel0})
      2'b00:   half_sel[0] = P_2K;
      2'b01:   half_sel[0] = P_4K;
      2'b10:   half_sel[0] = P_3K2;
      default: half_sel[0] = P_2K7;
    endcase
    unique case (ctrl_q.ref_a_freq_sel)
      2'b00:   half_sel[1] = P_RTC;
      2'b01:   half_sel[1] = P_64;
      2'b10:   half_sel[1] = P_16;
      default: half_sel[1] = P_SLOW;
    endcase
    unique case ({ctrl_q.ref_b_freq_sel_hi, ctrl_q.ref_b_freq_sel_lo})
      2'b00:   half_sel[2] = XTAL_76K ? P_19K : P_16K;
      2'b01:   half_sel[2] = P_64;
      2'b10:   half_sel[2] = P_16;
      default: half_sel[2] = P_SLOW;
    endcase
  end

  // ==========================================================
  // dividers, one per output; period changes only at a half-period edge
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] tog;
  logic           same_ab;

  // equal codes other than 00 mean the same rate on both refs
  assign same_ab = (ctrl_q.ref_a_freq_sel ==
                    {ctrl_q.ref_b_freq_sel_hi, ctrl_q.ref_b_freq_sel_lo}) &&
                   (ctrl_q.ref_a_freq_sel != 2'b00);

  for (genvar i = 0; i < NCH; i++) begin : g_div
    logic [31:0] cnt_q, cnt_d;
    logic        lvl_q, lvl_d;
    always_comb begin
      cnt_d = cnt_q - 32'h1;
      lvl_d = lvl_q;
      if (i == 2 && same_ab) begin
        // ref B waits at zero for a ref A edge, then takes the opposite
        // level; a phase is only ever stretched, so no runt appears
        if (cnt_q == 32'h0) begin
          cnt_d = 32'h0;
          if (tog[1]) begin
            cnt_d = half_sel[i] - 32'h1;
            lvl_d = lvl[1];
          end
        end
      end else if (cnt_q == 32'h0) begin
        cnt_d = half_sel[i] - 32'h1;
        lvl_d = ~lvl_q;
      end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        cnt_q <= 32'h0;
        lvl_q <= (i == 2);  // ref B starts opposite ref A
      end else begin
        cnt_q <= cnt_d;
        lvl_q <= lvl_d;
      end
    end
    assign lvl[i] = lvl_q;
    assign tog[i] = (cnt_q == 32'h0);
  end

  // ==========================================================
  // output stages
  logic tone_oe_q, tone_oe_d;
  logic ref_a_q,   ref_a_d;
  logic ref_b_q,   ref_b_d;

  always_comb begin
    tone_oe_d = alarm_enable_in & ~lvl[0];
    ref_a_d   = ~ctrl_q.ref_a_disable_opt & opt_wait_done & lvl[1];
    ref_b_d   = ref_b_enable_in ? lvl[2] : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tone_oe_q <= 1'b0;
      ref_a_q   <= 1'b0;
      ref_b_q   <= 1'b1;
    end else begin
      tone_oe_q <= tone_oe_d;
      ref_a_q   <= ref_a_d;
      ref_b_q   <= ref_b_d;
    end
  end

  assign alarm_tone_out  = 1'b0;  // open drain: only ever pulls low
  assign alarm_tone_oe   = tone_oe_q;
  assign ref_clock_out_a = ref_a_q;
  assign ref_clock_out_b = ref_b_q;

  // ==========================================================
  // assertions
  a_tone_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !alarm_enable_in |=> !alarm_tone_oe)
    else $error("alarm tone driven while disabled");

  a_tone_pulls_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (alarm_enable_in && !lvl[0]) |=> (alarm_tone_oe && !alarm_tone_out))
    else $error("alarm tone not pulled low in low phase");

  a_refb_idle_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ref_b_enable_in [*2] |-> ref_clock_out_b)
    else $error("ref B not high while disabled");

  a_refb_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ref_b_enable_in |=> ref_clock_out_b == $past(lvl[2]))
    else $error("ref B does not carry divider output");

  a_bat_set_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(battery_low_flag_out) |-> $past(smp && sense && hi_cnt_q == 2'h3))
    else $error("battery flag set without four high samples");

  a_bat_clr_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (smp && !sense && lo_cnt_q == 2'h3) |=> !battery_low_flag_out)
    else $error("battery flag not cleared after four low samples");

  a_sense_gated: assert property (@(posedge clk_sys) disable iff (!rst_b)
    smp |-> ($rose(rf_power_ctrl) && !ctrl_q.battery_detect_src_sel))
    else $error("battery sample outside rf power rise");

  a_sel_forced: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !ctrl_q.battery_detect_src_sel |-> (half_sel[0] == P_3K2 ||
                                        half_sel[0] == P_2K7))
    else $error("tone not limited while battery detect in use");

  a_refa_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!opt_wait_done || ctrl_q.ref_a_disable_opt) |=> !ref_clock_out_a)
    else $error("ref A active while gated off");

  a_no_runt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lvl[0] != $past(lvl[0])) |=> (lvl[0] == $past(lvl[0])) [*1])
    else $error("alarm divider toggled on consecutive cycles");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (|(irq_stat_q & irq_mask_q)) |=> irq)
    else $error("interrupt missing for unmasked status");

endmodule : alarm_ref_clock

`default_nettype wire

// ---- alarm_ref_far_side.sv ----
// far side model: tone pull-up and half-period meters for tone, ref a and ref b
`timescale 1ns/1ps
`default_nettype none
module alarm_ref_far_side (
  input  wire logic        clk_sys,
  input  wire logic        alarm_tone_oe,
  input  wire logic        ref_clock_out_a,
  input  wire logic        ref_clock_out_b,
  output var  logic        tone_pin,
  output var  logic [31:0] half_tone,
  output var  logic [31:0] half_a,
  output var  logic [31:0] half_b
);
  logic [2:0]  now_l;
  logic [2:0]  lvl_q;
  logic [31:0] cnt_q [3];
  logic [31:0] hp_q [3];
  // ==========================================================
  // pin levels: tone pin pulled up unless sunk, ref b read as driven
  always_comb tone_pin = alarm_tone_oe ? 1'b0 : 1'b1;
  always_comb now_l = {ref_clock_out_b, ref_clock_out_a, tone_pin};
  // ==========================================================
  // half-period meters
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (now_l[i] !== lvl_q[i]) begin
        hp_q[i]  <= cnt_q[i];
        cnt_q[i] <= 32'h1;
      end else begin
        cnt_q[i] <= cnt_q[i] + 32'h1;
      end
    end
    lvl_q <= now_l;
  end
  assign half_tone = hp_q[0];
  assign half_a    = hp_q[1];
  assign half_b    = hp_q[2];
endmodule : alarm_ref_far_side
`default_nettype wire

// ---- alarm_ref_clock_tb_top.sv ----
// self-checking bench for the alarm tone and reference clock block
`timescale 1ns/1ps
`default_nettype none
module alarm_ref_clock_tb_top;
  import alarm_ref_pkg::*;
  // half periods: tone, ref a, ref b per select value
  localparam int unsigned T_2K  = 10, T_4K = 5, T_3K2 = 8, T_2K7 = 9;
  localparam int unsigned T_RTC = 3, T_16K = 4, T_19K = 6;
  localparam int unsigned T_64  = 12, T_16 = 16, T_SLOW = 20;
  localparam logic [31:0] HALF_TAB [3][4] =
    '{'{T_2K, T_4K, T_3K2, T_2K7}, '{T_RTC, T_64, T_16, T_SLOW},
      '{T_16K, T_64, T_16, T_SLOW}};
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  reg_req_t    reg_req = '0;
  logic        sel0 = 1'b0, sel1 = 1'b0, alarm_en = 1'b0, b_en = 1'b0;
  logic        rfp = 1'b0, wait_done = 1'b0;
  logic [31:0] reg_rdata, half_tone, half_a, half_b, d;
  logic        tone_oe, tone_out, ref_a, ref_b, bat_flag, irq, tone_pin;
  logic        exp_flag = 1'b0, last_s = 1'b0;
  int          run_n = 0, eq_n, n_mismatch = 0, n_checks = 0;
  int          seed = 16579;

  always #5 clk_sys = ~clk_sys;

  alarm_ref_clock #(.P_2K(T_2K), .P_4K(T_4K), .P_3K2(T_3K2), .P_2K7(T_2K7),
    .P_RTC(T_RTC), .P_16K(T_16K), .P_19K(T_19K), .P_64(T_64), .P_16(T_16),
    .P_SLOW(T_SLOW)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .alarm_freq_sel0(sel0), .alarm_freq_sel1(sel1),
    .alarm_enable_in(alarm_en), .ref_b_enable_in(b_en),
    .rf_power_ctrl(rfp), .opt_wait_done(wait_done),
    .alarm_tone_out(tone_out), .alarm_tone_oe(tone_oe),
    .ref_clock_out_a(ref_a), .ref_clock_out_b(ref_b),
    .battery_low_flag_out(bat_flag), .irq(irq));

  alarm_ref_far_side far (.clk_sys(clk_sys), .alarm_tone_oe(tone_oe),
    .ref_clock_out_a(ref_a), .ref_clock_out_b(ref_b), .tone_pin(tone_pin),
    .half_tone(half_tone), .half_a(half_a), .half_b(half_b));

  // ==========================================================
  // expectations and checks
  function automatic logic [31:0] exp_half(input int k, input logic [1:0] s);
    return HALF_TAB[k][s];
  endfunction : exp_half

  function automatic logic flag_next(input logic s);
    run_n = (s === last_s) ? run_n + 1 : 1;
    last_s = s;
    if (run_n >= 4) exp_flag = s;
    return exp_flag;
  endfunction : flag_next

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // drivers
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk_sys);
    reg_req.we <= 1'b0;
  endtask : wr

  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk_sys);
    reg_req.re <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rchk

  task automatic smp(input logic s, input logic live);
    @(posedge clk_sys);
    sel1 <= s;
    rfp  <= 1'b1;
    @(posedge clk_sys);
    rfp <= 1'b0;
    idle(2);
    if (live) chk("battery_low_flag_out", bat_flag, flag_next(s));
  endtask : smp

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    idle(2);
    chk("ref_b in reset", ref_b, 1);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk("ctrl", OFS_CTRL, 32'h03);
    rchk("irq_mask", OFS_IRQ_MASK, 32'h0);
    wr(4'h2, 32'hFFFF_FFFF);
    rchk("unmapped", 4'h2, 32'h0);
    rchk("ctrl kept", OFS_CTRL, 32'h03);
    idle(40);
    chk("tone pin idle", {tone_oe, tone_pin}, 2'h1);
    @(posedge clk_sys);
    alarm_en <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      {sel1, sel0} <= 2'(s);
      idle(80);
      chk("half_tone", half_tone, exp_half(0, 2'(s)));
    end
    chk("tone data", tone_out, 0);
    chk("ref_b off", ref_b, 1);
    @(posedge clk_sys);
    b_en <= 1'b1;
    for (int s = 1; s < 5; s++) begin
      wr(OFS_CTRL, 32'((s % 4) << 4) | 32'h3);
      idle(80);
      chk("half_b", half_b, exp_half(2, 2'(s % 4)));
    end
    wr(OFS_CTRL, 32'h1);
    idle(40);
    chk("ref_a before wait end", ref_a, 0);
    @(posedge clk_sys);
    wait_done <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'(s << 4 | s << 2) | 32'h1);
      idle(80);
      chk("half_a", half_a, exp_half(1, 2'(s)));
      eq_n = 0;
      for (int c = 0; c < 40; c++) begin
        idle(1);
        eq_n += int'(ref_a === ref_b);
      end
      if (s > 0) chk("refs in opposite phase", eq_n, 0);
    end
    wr(OFS_CTRL, 32'h3);
    idle(40);
    chk("ref_a disabled", ref_a, 0);
    for (int i = 0; i < 4; i++) smp(1'b1, 1'b0);
    chk("no sampling", bat_flag, 0);
    wr(OFS_CTRL, 32'h2);
    @(posedge clk_sys);
    {sel1, sel0} <= 2'h0;
    idle(80);
    chk("half_tone forced", half_tone, exp_half(0, 2'h2));
    rchk("status", OFS_STATUS, 32'h6);
    for (int i = 0; i < 4; i++) smp(1'b1, 1'b1);
    chk("irq masked", irq, 0);
    rchk("irq_stat", OFS_IRQ_STAT, 32'h5);
    wr(OFS_IRQ_MASK, 32'h1);
    idle(2);
    chk("irq raised", irq, 1);
    wr(OFS_IRQ_STAT, 32'h1);
    idle(2);
    chk("irq cleared", irq, 0);
    for (int i = 0; i < 8; i++) smp(i == 3 ? 1'b1 : 1'b0, 1'b1);
    rchk("irq_stat fell", OFS_IRQ_STAT, 32'h6);
    for (int i = 0; i < 24; i++) smp(1'($random(seed)), 1'b1);
    close_out();
  end
endmodule : alarm_ref_clock_tb_top
`default_nettype wire
